/* verilog/pse_consts.svh */
// register offsets, field positions, reset values and masks
`ifndef PSE_CONSTS_SVH
`define PSE_CONSTS_SVH

`define ADDR_IRQ_SUMMARY      8'h00
`define ADDR_IRQ_MASK         8'h01
`define ADDR_GLOBAL_CMD       8'h0b
`define ADDR_C4_EVENT         8'h40
`define ADDR_C4_EVENT_RDCLR   8'h41
`define ADDR_C4_DET_CLASS     8'h42
`define ADDR_C4_POWER         8'h43
`define ADDR_C4_SETUP         8'h44
`define ADDR_C4_OVL_TIMER     8'h45
`define ADDR_C4_OC_THRESH     8'h46
`define ADDR_C4_CMD           8'h47
`define ADDR_C4_CUR_LO        8'h49
`define ADDR_C4_CUR_HI        8'h4a
`define ADDR_C4_VOLT_LO       8'h4b
`define ADDR_C4_VOLT_HI       8'h4c
`define ADDR_C4_DET_RES       8'h4d

`define GCMD_CLEAR_ALL_BIT    7
`define GCMD_RELEASE_BIT      6

`define SETUP_LEGACY_BIT      7
`define SETUP_SPAN_BIT        6
`define SETUP_DISC_BIT        5
`define SETUP_PRIO_BIT        4
`define SETUP_CLASS_EN_BIT    3
`define SETUP_DET_EN_BIT      2
`define SETUP_MODE_HI         1
`define SETUP_MODE_LO         0

`define RST_MASK              8'h00
`define RST_SETUP             8'h00
`define RST_OVL_TIMER         8'h00
`define RST_OC_THRESH         8'h54
`define RST_BYTE              8'h00

`define DET_CLASS_VALID       8'h77
`define POWER_VALID           8'h0f
`define OVL_TIMER_VALID       8'h6f
`define OC_THRESH_VALID       8'h7f
`define CMD_VALID             8'h1f

`define BITS_PER_BYTE         4'h8
`define DEV_ADDR_DEFAULT      7'h20

`endif

/* verilog/pse_pkg.sv */
// types shared by the summary/interrupt design
package pse_pkg;

   typedef enum logic [8:0] {
      L_IDLE     = 9'h001,
      L_ADDR     = 9'h002,
      L_ADDR_ACK = 9'h004,
      L_PTR      = 9'h008,
      L_WR_ACK   = 9'h010,
      L_WDATA    = 9'h020,
      L_RDATA    = 9'h040,
      L_RD_ACK   = 9'h080,
      L_RLOAD    = 9'h100
   } link_state_t;

   typedef struct packed {
      link_state_t st;
      logic        scl_q;
      logic        sda_q;
      logic [3:0]  bitcnt;
      logic [7:0]  shreg;
      logic [7:0]  ptr;
      logic        rw;
      logic        sda_drive;
      logic [7:0]  mask;
      logic [7:0]  setup;
      logic [7:0]  otimer;
      logic [7:0]  ithr;
      logic [7:0]  cmd;
      logic        clr_all;
      logic        release_pin;
      logic        rd_clr;
   } top_state_t;

endpackage : pse_pkg

/* verilog/irq_link_if.sv */
// carrier between the register front end and the summary core
`timescale 1ns/1ps
`default_nettype none
interface irq_link_if;
   logic [7:0] sources;
   logic [7:0] mask;
   logic       clr_all;
   logic       release_pin;
   logic [7:0] summary;
   logic       int_n;

   modport core (input sources, input mask, input clr_all,
                 input release_pin, output summary, output int_n);
   modport ctl  (output sources, output mask, output clr_all,
                 output release_pin, input summary, input int_n);
endinterface : irq_link_if
`default_nettype wire

/* verilog/chan_event_bank.sv */
// sticky event flags of one channel with a read-to-clear path
`timescale 1ns/1ps
`default_nettype none
module chan_event_bank #(
   parameter int WIDTH = 8
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] event_set,
   input  wire logic             rd_clr,
   output logic      [WIDTH-1:0] flags,
   output logic                  any
);
   typedef struct packed {
      logic [WIDTH-1:0] flags;
   } bank_state_t;

   bank_state_t r;
   bank_state_t next_r;

   // a new event in the clearing cycle survives the clear
   always_comb begin
      next_r = r;
      next_r.flags = event_set | (rd_clr ? '0 : r.flags);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign flags = r.flags;
   assign any   = |r.flags;
endmodule : chan_event_bank
`default_nettype wire

/* verilog/irq_summary_core.sv */
// summary register and interrupt pin gating
`timescale 1ns/1ps
`default_nettype none
module irq_summary_core (
   input  wire logic clk,
   input  wire logic rst,
   irq_link_if.core  lnk
);
   typedef struct packed {
      logic [7:0] prev_src;
      logic [7:0] summary;
      logic       released;
      logic       int_n;
   } core_state_t;

   core_state_t r;
   core_state_t next_r;

   always_comb begin
      logic [7:0] fresh;
      logic       pending;
      fresh  = '0;
      pending = 1'b0;
      next_r = r;
      next_r.prev_src = lnk.sources;
      fresh = lnk.sources & ~r.prev_src;
      // a bit falls with its source; clear-all loses to a fresh event
      next_r.summary = (lnk.clr_all ? 8'h00 : (r.summary & lnk.sources))
                       | fresh;
      if (|(fresh & lnk.mask)) begin
         next_r.released = 1'b0;
      end else if (lnk.release_pin) begin
         next_r.released = 1'b1;
      end
      // mask only gates the pin, never the stored bits
      pending = |(next_r.summary & lnk.mask);
      next_r.int_n = ~(pending & ~next_r.released);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         r <= '{prev_src: 8'h00, summary: 8'h00, released: 1'b0,
                int_n: 1'b1};
      end else begin
         r <= next_r;
      end
   end

   assign lnk.summary = r.summary;
   assign lnk.int_n   = r.int_n;
endmodule : irq_summary_core
`default_nettype wire

/* verilog/pse_irq_top.sv */
// serial register front end, channel 4 registers and interrupt summary
`timescale 1ns/1ps
`default_nettype none
`include "pse_consts.svh"
module pse_irq_top #(
   parameter logic [6:0] DEV_ADDR = `DEV_ADDR_DEFAULT // arbitrary value
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        scl,
   input  wire logic        sda_in,
   output logic             sda_out,
   output logic             sda_oe,
   output logic             int_n,
   input  wire logic [2:0]  other_port_events,
   input  wire logic [3:0]  global_event_hi,
   input  wire logic [7:0]  chan4_event_set,
   input  wire logic [7:0]  chan4_detect_class,
   input  wire logic [7:0]  chan4_power,
   input  wire logic [15:0] chan4_current,
   input  wire logic [15:0] chan4_voltage,
   input  wire logic [7:0]  chan4_detres,
   output logic             chan4_legacy_en,
   output logic             chan4_span,
   output logic             chan4_disconnect_en,
   output logic             chan4_priority,
   output logic             chan4_class_en,
   output logic             chan4_detect_en,
   output logic [1:0]       chan4_mode,
   output logic [7:0]       chan4_overload_timer,
   output logic [7:0]       chan4_current_limit,
   output logic [7:0]       chan4_command
);
   pse_pkg::top_state_t r;
   pse_pkg::top_state_t next_r;

   irq_link_if lnk ();

   logic [7:0] c4_flags;
   logic       c4_any;

   chan_event_bank #(
      .WIDTH     (8)
   ) u_c4_bank (
      .clk       (clk),
      .rst       (rst),
      .event_set (chan4_event_set),
      .rd_clr    (r.rd_clr),
      .flags     (c4_flags),
      .any       (c4_any)
   );

   irq_summary_core u_core (
      .clk (clk),
      .rst (rst),
      .lnk (lnk.core)
   );

   // sources: global high nibble, then channel 4 and the other three
   assign lnk.sources     = {global_event_hi, c4_any,
                             other_port_events};
   assign lnk.mask        = r.mask;
   assign lnk.clr_all     = r.clr_all;
   assign lnk.release_pin = r.release_pin;

   // register read mux; reserved bits and unmapped addresses read zero
   function automatic logic [7:0] reg_read(input logic [7:0] a);
      logic [7:0] d;
      d = `RST_BYTE;
      if (a == `ADDR_IRQ_SUMMARY) begin
         d = lnk.summary;
      end else if (a == `ADDR_IRQ_MASK) begin
         d = r.mask;
      end else if (a == `ADDR_C4_EVENT) begin
         d = c4_flags;
      end else if (a == `ADDR_C4_EVENT_RDCLR) begin
         d = c4_flags;
      end else if (a == `ADDR_C4_DET_CLASS) begin
         d = chan4_detect_class & `DET_CLASS_VALID;
      end else if (a == `ADDR_C4_POWER) begin
         d = chan4_power & `POWER_VALID;
      end else if (a == `ADDR_C4_SETUP) begin
         d = r.setup;
      end else if (a == `ADDR_C4_OVL_TIMER) begin
         d = r.otimer;
      end else if (a == `ADDR_C4_OC_THRESH) begin
         d = r.ithr;
      end else if (a == `ADDR_C4_CUR_LO) begin
         d = chan4_current[7:0];
      end else if (a == `ADDR_C4_CUR_HI) begin
         d = chan4_current[15:8];
      end else if (a == `ADDR_C4_VOLT_LO) begin
         d = chan4_voltage[7:0];
      end else if (a == `ADDR_C4_VOLT_HI) begin
         d = chan4_voltage[15:8];
      end else if (a == `ADDR_C4_DET_RES) begin
         d = chan4_detres;
      end
      return d;
   endfunction : reg_read

   always_comb begin
      logic rise;
      logic fall;
      logic start_c;
      logic stop_c;
      logic [7:0] rd;
      rise    = 1'b0;
      fall    = 1'b0;
      start_c = 1'b0;
      stop_c  = 1'b0;
      rd      = `RST_BYTE;
      next_r  = r;
      next_r.scl_q       = scl;
      next_r.sda_q       = sda_in;
      next_r.cmd         = `RST_BYTE;
      next_r.clr_all     = 1'b0;
      next_r.release_pin = 1'b0;
      next_r.rd_clr      = 1'b0;
      rise    = ~r.scl_q & scl;
      fall    = r.scl_q & ~scl;
      start_c = r.scl_q & scl & r.sda_q & ~sda_in;
      stop_c  = r.scl_q & scl & ~r.sda_q & sda_in;
      rd      = reg_read(r.ptr);

      if (start_c) begin
         next_r.st        = pse_pkg::L_ADDR;
         next_r.bitcnt    = 4'h0;
         next_r.sda_drive = 1'b0;
      end else if (stop_c) begin
         next_r.st        = pse_pkg::L_IDLE;
         next_r.sda_drive = 1'b0;
      end else if (rise) begin
         case (r.st)
            pse_pkg::L_ADDR, pse_pkg::L_PTR, pse_pkg::L_WDATA: begin
               next_r.shreg  = {r.shreg[6:0], sda_in};
               next_r.bitcnt = r.bitcnt + 4'h1;
            end
            pse_pkg::L_RD_ACK: begin
               // a high ninth bit is the host's not-acknowledge
               next_r.st = sda_in ? pse_pkg::L_IDLE : pse_pkg::L_RLOAD;
            end
            default: begin
               next_r.st = r.st;
            end
         endcase
      end else if (fall) begin
         case (r.st)
            pse_pkg::L_ADDR: begin
               if (r.bitcnt == `BITS_PER_BYTE) begin
                  if (r.shreg[7:1] == DEV_ADDR) begin
                     next_r.rw        = r.shreg[0];
                     next_r.sda_drive = 1'b1;
                     next_r.st        = pse_pkg::L_ADDR_ACK;
                  end else begin
                     next_r.st = pse_pkg::L_IDLE;
                  end
               end
            end
            pse_pkg::L_ADDR_ACK: begin
               next_r.bitcnt = 4'h0;
               if (r.rw) begin
                  next_r.shreg     = {rd[6:0], 1'b0};
                  next_r.sda_drive = ~rd[7];
                  next_r.bitcnt    = 4'h1;
                  next_r.st        = pse_pkg::L_RDATA;
                  next_r.rd_clr    = (r.ptr == `ADDR_C4_EVENT_RDCLR);
                  next_r.ptr       = r.ptr + 8'h01;
               end else begin
                  next_r.sda_drive = 1'b0;
                  next_r.st        = pse_pkg::L_PTR;
               end
            end
            pse_pkg::L_PTR: begin
               if (r.bitcnt == `BITS_PER_BYTE) begin
                  next_r.ptr       = r.shreg;
                  next_r.sda_drive = 1'b1;
                  next_r.st        = pse_pkg::L_WR_ACK;
               end
            end
            pse_pkg::L_WDATA: begin
               if (r.bitcnt == `BITS_PER_BYTE) begin
                  // writes to reserved or read-only offsets do nothing
                  if (r.ptr == `ADDR_IRQ_MASK) begin
                     next_r.mask = r.shreg;
                  end else if (r.ptr == `ADDR_GLOBAL_CMD) begin
                     next_r.clr_all =
                        r.shreg[`GCMD_CLEAR_ALL_BIT];
                     next_r.release_pin =
                        r.shreg[`GCMD_RELEASE_BIT];
                  end else if (r.ptr == `ADDR_C4_SETUP) begin
                     next_r.setup = r.shreg;
                  end else if (r.ptr == `ADDR_C4_OVL_TIMER) begin
                     next_r.otimer = r.shreg & `OVL_TIMER_VALID;
                  end else if (r.ptr == `ADDR_C4_OC_THRESH) begin
                     next_r.ithr = r.shreg & `OC_THRESH_VALID;
                  end else if (r.ptr == `ADDR_C4_CMD) begin
                     next_r.cmd = r.shreg & `CMD_VALID;
                  end
                  next_r.ptr       = r.ptr + 8'h01;
                  next_r.sda_drive = 1'b1;
                  next_r.st        = pse_pkg::L_WR_ACK;
               end
            end
            pse_pkg::L_WR_ACK: begin
               next_r.sda_drive = 1'b0;
               next_r.bitcnt    = 4'h0;
               next_r.st        = pse_pkg::L_WDATA;
            end
            pse_pkg::L_RDATA: begin
               if (r.bitcnt == `BITS_PER_BYTE) begin
                  next_r.sda_drive = 1'b0;
                  next_r.st        = pse_pkg::L_RD_ACK;
               end else begin
                  next_r.sda_drive = ~r.shreg[7];
                  next_r.shreg     = {r.shreg[6:0], 1'b0};
                  next_r.bitcnt    = r.bitcnt + 4'h1;
               end
            end
            pse_pkg::L_RLOAD: begin
               // next byte of a burst read, pointer auto-increments
               next_r.shreg     = {rd[6:0], 1'b0};
               next_r.sda_drive = ~rd[7];
               next_r.bitcnt    = 4'h1;
               next_r.st        = pse_pkg::L_RDATA;
               next_r.rd_clr    = (r.ptr == `ADDR_C4_EVENT_RDCLR);
               next_r.ptr       = r.ptr + 8'h01;
            end
            default: begin
               next_r.st = r.st;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         r <= '{st: pse_pkg::L_IDLE, scl_q: 1'b1, sda_q: 1'b1,
                bitcnt: 4'h0, shreg: `RST_BYTE, ptr: `RST_BYTE,
                rw: 1'b0, sda_drive: 1'b0, mask: `RST_MASK,
                setup: `RST_SETUP, otimer: `RST_OVL_TIMER,
                ithr: `RST_OC_THRESH, cmd: `RST_BYTE,
                clr_all: 1'b0, release_pin: 1'b0, rd_clr: 1'b0};
      end else begin
         r <= next_r;
      end
   end

   // separate data-out pin: pulled low while driven
   assign sda_out = ~r.sda_drive;
   assign sda_oe  = r.sda_drive;
   assign int_n   = lnk.int_n;

   assign chan4_legacy_en      = r.setup[`SETUP_LEGACY_BIT];
   assign chan4_span           = r.setup[`SETUP_SPAN_BIT];
   assign chan4_disconnect_en  = r.setup[`SETUP_DISC_BIT];
   assign chan4_priority       = r.setup[`SETUP_PRIO_BIT];
   assign chan4_class_en       = r.setup[`SETUP_CLASS_EN_BIT];
   assign chan4_detect_en      = r.setup[`SETUP_DET_EN_BIT];
   assign chan4_mode           = r.setup[`SETUP_MODE_HI:`SETUP_MODE_LO];
   assign chan4_overload_timer = r.otimer;
   assign chan4_current_limit  = r.ithr;
   assign chan4_command        = r.cmd;
endmodule : pse_irq_top
`default_nettype wire

/* tb/pse_irq_monitor.sv */
// checker of interrupt pin, channel 4 setup outputs and serial pin timing
`timescale 1ns/1ps
`default_nettype none
`include "pse_consts.svh"
module pse_irq_monitor (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        scl,
   input wire logic        sda_out,
   input wire logic        sda_oe,
   input wire logic        int_n,
   input wire logic [2:0]  other_port_events,
   input wire logic [3:0]  global_event_hi,
   input wire logic [7:0]  chan4_event_set,
   input wire logic [7:0]  setup_bits,
   input wire logic [7:0]  chan4_overload_timer,
   input wire logic [7:0]  chan4_current_limit,
   input wire logic [7:0]  chan4_command
);
   logic [3:0] src_age;
   logic [3:0] scl_age;
   logic       scl_q;
   logic [6:0] src_q;
   logic       src_edge;

   // any change of a level source or any event pulse may move the pin
   assign src_edge = ({other_port_events, global_event_hi} != src_q) ||
                     (|chan4_event_set);

   always_ff @(posedge clk) begin
      if (rst) begin
         scl_q   <= 1'b1;
         src_q   <= {other_port_events, global_event_hi};
         src_age <= 4'hf;
         scl_age <= 4'hf;
      end else begin
         scl_q   <= scl;
         src_q   <= {other_port_events, global_event_hi};
         src_age <= src_edge ? 4'h0 : src_age + {3'h0, src_age != 4'hf};
         scl_age <= (scl_q && !scl) ? 4'h0 :
                    scl_age + {3'h0, scl_age != 4'hf};
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   reset_values_a: assert property (
      $fell(rst) |-> int_n && !sda_oe && setup_bits == 8'h00 &&
      chan4_current_limit == `RST_OC_THRESH)
      else $error("bad value right after reset");
   irq_fall_cause_a: assert property (
      $fell(int_n) |-> src_age <= 4'h3 || scl_age <= 4'h8)
      else $error("interrupt pin fell without a cause");
   irq_rise_cause_a: assert property (
      $rose(int_n) |-> src_age <= 4'h3 || scl_age <= 4'h8)
      else $error("interrupt pin released without a cause");
   setup_by_host_a: assert property (
      $changed(setup_bits) |-> scl_age <= 4'h4)
      else $error("setup changed outside a host write");
   sda_timing_a: assert property (
      $changed(sda_oe) |-> scl_age <= 4'h3)
      else $error("data pin drive changed away from clock fall");
   sda_level_a: assert property (
      $past(scl) && scl |-> $stable(sda_oe))
      else $error("data pin drive moved while the clock was high");
   reserved_zero_a: assert property (
      (chan4_overload_timer & ~(`OVL_TIMER_VALID)) == 8'h00 &&
      (chan4_current_limit & ~(`OC_THRESH_VALID)) == 8'h00)
      else $error("reserved bit set in a setup output");
   cmd_pulse_a: assert property (
      chan4_command != 8'h00 |-> (chan4_command & ~(`CMD_VALID)) == 8'h00
      ##1 chan4_command == 8'h00)
      else $error("command strobe not a clean single pulse");
endmodule : pse_irq_monitor

bind pse_irq_top pse_irq_monitor mon_u (.clk(clk), .rst(rst), .scl(scl),
   .sda_out(sda_out), .sda_oe(sda_oe), .int_n(int_n),
   .other_port_events(other_port_events), .global_event_hi(global_event_hi),
   .chan4_event_set(chan4_event_set),
   .setup_bits({chan4_legacy_en, chan4_span, chan4_disconnect_en,
      chan4_priority, chan4_class_en, chan4_detect_en, chan4_mode}),
   .chan4_overload_timer(chan4_overload_timer),
   .chan4_current_limit(chan4_current_limit), .chan4_command(chan4_command));
`default_nettype wire

/* tb/serial_host_model.sv */
// host side of the serial link: register writes and pointer reads
`timescale 1ns/1ps
`default_nettype none
`include "pse_consts.svh"
module serial_host_model #(
   parameter logic [6:0] DEV = `DEV_ADDR_DEFAULT
) (
   input  wire logic clk,
   output logic      scl,
   output logic      sda_line,
   input  wire logic sda_out,
   input  wire logic sda_oe
);
   logic sda_h;
   int   nacks;

   // pulled-up line: low while either party pulls it down
   assign sda_line = sda_h & ~(sda_oe & ~sda_out);

   initial begin
      scl = 1'b1;
      sda_h = 1'b1;
      nacks = 0;
   end

   task automatic hold(input int n);
      repeat (n) @(negedge clk);
   endtask : hold

   // data moves only while the clock is low, sampled mid high phase
   task automatic clk_bit(input logic b, output logic got);
      sda_h = b;
      hold(6);
      scl = 1'b1;
      hold(3);
      got = sda_line;
      hold(3);
      scl = 1'b0;
   endtask : clk_bit

   task automatic start();
      sda_h = 1'b1;
      hold(6);
      scl = 1'b1;
      hold(6);
      sda_h = 1'b0;
      hold(6);
      scl = 1'b0;
   endtask : start

   task automatic stop();
      sda_h = 1'b0;
      hold(6);
      scl = 1'b1;
      hold(6);
      sda_h = 1'b1;
      hold(6);
   endtask : stop

   task automatic send(input logic [7:0] v);
      logic a;
      for (int i = 7; i >= 0; i--) clk_bit(v[i], a);
      clk_bit(1'b1, a);
      if (a !== 1'b0) nacks++;
   endtask : send

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      if (!(a inside {8'h01, 8'h0b, 8'h44, 8'h45, 8'h46,
                      8'h47})) return;
      start();
      send({DEV, 1'b0});
      send(a);
      send(d);
      stop();
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      logic n;
      start();
      send({DEV, 1'b0});
      send(a);
      start();
      send({DEV, 1'b1});
      for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
      clk_bit(1'b1, n);
      stop();
   endtask : rd

   // two-byte burst read, low byte first: ack the first, not-ack the last
   task automatic rd2(input logic [7:0] a, output logic [15:0] d);
      logic n;
      start();
      send({DEV, 1'b0});
      send(a);
      start();
      send({DEV, 1'b1});
      for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
      clk_bit(1'b0, n);
      for (int i = 15; i >= 8; i--) clk_bit(1'b1, d[i]);
      clk_bit(1'b1, n);
      stop();
   endtask : rd2
endmodule : serial_host_model
`default_nettype wire

/* tb/pse_irq_summary_and_port4_regs_tb_top.sv */
// self-checking bench of the interrupt summary and channel 4 registers
`timescale 1ns/1ps
`default_nettype none
`include "pse_consts.svh"
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin \
   mismatches++; \
   $display("FAIL t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module pse_irq_summary_and_port4_regs_tb_top;
   logic        clk, rst, scl, sda_in, sda_out, sda_oe, int_n;
   logic [2:0]  oth;
   logic [3:0]  glb;
   logic [7:0]  ev, dcl, pwr, dres, otim, ilim, cmd, cmd_seen, rv;
   logic [15:0] cur, vol, rd16;
   logic [7:0]  setup;
   int          mismatches = 0;
   int          tests_run = 0;
   logic [7:0]  ra [14] = '{8'h00, 8'h40, 8'h42, 8'h43, 8'h44, 8'h45,
      8'h46, 8'h49, 8'h4a, 8'h4b, 8'h4c, 8'h4d, 8'h48, 8'h47};
   logic [7:0]  re [14] = '{8'h00, 8'h00, 8'h35, 8'h0a, 8'h00, 8'h00,
      8'h54, 8'h34, 8'h12, 8'hcd, 8'hab, 8'h5a, 8'h00, 8'h00};

   pse_irq_top dut_u (.clk(clk), .rst(rst), .scl(scl), .sda_in(sda_in),
      .sda_out(sda_out), .sda_oe(sda_oe), .int_n(int_n),
      .other_port_events(oth), .global_event_hi(glb), .chan4_event_set(ev),
      .chan4_detect_class(dcl), .chan4_power(pwr), .chan4_current(cur),
      .chan4_voltage(vol), .chan4_detres(dres),
      .chan4_legacy_en(setup[7]), .chan4_span(setup[6]),
      .chan4_disconnect_en(setup[5]), .chan4_priority(setup[4]),
      .chan4_class_en(setup[3]), .chan4_detect_en(setup[2]),
      .chan4_mode(setup[1:0]), .chan4_overload_timer(otim),
      .chan4_current_limit(ilim), .chan4_command(cmd));

   serial_host_model host_u (.clk(clk), .scl(scl), .sda_line(sda_in),
      .sda_out(sda_out), .sda_oe(sda_oe));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // the strobe lasts one cycle, so keep the last one seen
   always @(posedge clk) if (cmd != 8'h00) cmd_seen <= cmd;

   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask : tick

   task automatic print_verdict();
      if (mismatches == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : print_verdict

   initial begin
      repeat (100000) @(posedge clk);
      mismatches++;
      print_verdict();
   end

   initial begin
      rst = 1'b1;
      oth = 3'h0;
      glb = 4'h0;
      ev = 8'h00;
      dcl = 8'hb5;
      pwr = 8'hfa;
      cur = 16'h1234;
      vol = 16'habcd;
      dres = 8'h5a;
      cmd_seen = 8'h00;
      tick(3);
      rst = 1'b0;
      tick(2);
      for (int i = 0; i < 14; i++) begin
         host_u.rd(ra[i], rv);
         `CHK(rv, re[i])
      end
      host_u.rd2(`ADDR_C4_CUR_LO, rd16);
      `CHK(rd16, 16'h1234)
      host_u.rd2(`ADDR_C4_VOLT_LO, rd16);
      `CHK(rd16, 16'habcd)
      host_u.wr(`ADDR_C4_SETUP, 8'hb5);
      `CHK(setup, 8'hb5)
      host_u.rd(`ADDR_C4_SETUP, rv);
      `CHK(rv, 8'hb5)
      host_u.wr(`ADDR_C4_OVL_TIMER, 8'hff);
      `CHK(otim, 8'h6f)
      host_u.wr(`ADDR_C4_OC_THRESH, 8'hff);
      `CHK(ilim, 8'h7f)
      host_u.wr(`ADDR_C4_CMD, 8'hff);
      `CHK(cmd_seen, 8'h1f)
      host_u.wr(`ADDR_IRQ_MASK, 8'hff);
      oth = 3'h2;
      tick(2);
      `CHK(int_n, 1'b0)
      glb = 4'ha;
      host_u.rd(`ADDR_IRQ_SUMMARY, rv);
      `CHK(rv, 8'ha2)
      host_u.wr(`ADDR_IRQ_MASK, 8'h00);
      `CHK(int_n, 1'b1)
      host_u.rd(`ADDR_IRQ_SUMMARY, rv);
      `CHK(rv, 8'ha2)
      host_u.wr(`ADDR_IRQ_MASK, 8'hff);
      `CHK(int_n, 1'b0)
      oth = 3'h0;
      glb = 4'h0;
      tick(2);
      `CHK(int_n, 1'b1)
      ev = 8'h24;
      tick(1);
      ev = 8'h00;
      tick(2);
      `CHK(int_n, 1'b0)
      host_u.rd(`ADDR_C4_EVENT, rv);
      `CHK(rv, 8'h24)
      host_u.rd(`ADDR_IRQ_SUMMARY, rv);
      `CHK(rv, 8'h08)
      host_u.rd(`ADDR_C4_EVENT_RDCLR, rv);
      `CHK(rv, 8'h24)
      host_u.rd(`ADDR_C4_EVENT, rv);
      `CHK(rv, 8'h00)
      host_u.rd(`ADDR_IRQ_SUMMARY, rv);
      `CHK(rv, 8'h00)
      `CHK(int_n, 1'b1)
      oth = 3'h1;
      tick(2);
      host_u.wr(`ADDR_GLOBAL_CMD, 8'h80);
      host_u.rd(`ADDR_IRQ_SUMMARY, rv);
      `CHK(rv, 8'h00)
      `CHK(int_n, 1'b1)
      oth = 3'h5;
      tick(2);
      `CHK(int_n, 1'b0)
      host_u.wr(`ADDR_GLOBAL_CMD, 8'h40);
      `CHK(int_n, 1'b1)
      host_u.rd(`ADDR_IRQ_SUMMARY, rv);
      `CHK(rv, 8'h04)
      `CHK(host_u.nacks, 0)
      print_verdict();
   end
endmodule : pse_irq_summary_and_port4_regs_tb_top
`default_nettype wire
